/* File: spl_pkg.sv */
package spl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SPL_AW = 16;
  localparam int SPL_DW = 16;
  localparam int SPL_PCW = 23;

  // ----------------------------------------------------------------
  // Stack constants
  // ----------------------------------------------------------------
  localparam logic [15:0] SPL_WORD_STEP = 16'h0002;
  localparam logic [15:0] SPL_LOWER_BOUND = 16'h0800;
  localparam logic [15:0] SPL_SP_RESET = 16'h0800;
  localparam logic [15:0] SPL_ALIGN_MASK = 16'hFFFE;
  localparam logic [7:0] SPL_ZERO_BYTE = 8'h00;
  localparam int SPL_PC_HI_LSB = 16;

  // ----------------------------------------------------------------
  // Push kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPL_KIND_DATA = 2'b00,
    SPL_KIND_CALL = 2'b01,
    SPL_KIND_EXC = 2'b10
  } spl_kind_t;

  typedef enum logic [1:0] {
    SPL_ST_IDLE = 2'b00,
    SPL_ST_PC_HI = 2'b01
  } spl_state_t;

endpackage

/* File: spl_bound_cmp.sv */
module spl_bound_cmp
  import spl_pkg::*;
(
  // Address under test
  input wire logic [SPL_AW-1:0] addr,
  input wire logic [SPL_AW-1:0] limit,
  // Verdicts
  output logic over,
  output logic under
);

  // ----------------------------------------------------------------
  // Bound comparison
  // ----------------------------------------------------------------
  // Equal to limit is still legal; only beyond it is an overflow
  always_comb begin
    over = (addr > limit);
    under = (addr < SPL_LOWER_BOUND);
  end

endmodule // spl_bound_cmp

/* File: spl_stack_unit.sv */
// Behaviour
// - working_reg_fifteen is stack pointer, points at first free word, grows upward.
// - Push writes at pointer then increments; pop decrements then reads.
// - Call pushes of the program counter clear the upper byte.
// - Exception pushes put status_low_byte in the upper byte instead.
// - stack_limit is not initialised by reset.
// - Bit zero of stack_limit is forced to zero.
// - Every address formed through the stack pointer is compared with stack_limit; ea_addr only in cycles without push_req, pop_req or busy.
// - Push at pointer equal to limit is fine; next push traps.
// - Address below lower bound raises an underflow stack error.
module spl_stack_unit
  import spl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Direct writes of the pointer and limit
  input wire logic sp_we,
  input wire logic [SPL_AW-1:0] sp_wdata,
  input wire logic limit_we,
  input wire logic [SPL_AW-1:0] limit_wdata,
  // Push and pop requests
  input wire logic push_req,
  input wire logic [1:0] push_kind,
  input wire logic [SPL_DW-1:0] push_data,
  input wire logic [SPL_PCW-1:0] push_pc,
  input wire logic [7:0] status_low_byte,
  input wire logic pop_req,
  // Other addresses formed through the pointer
  input wire logic ea_valid,
  input wire logic [SPL_AW-1:0] ea_addr,
  // Memory access toward data space
  output logic mem_req,
  output logic mem_we,
  output logic [SPL_AW-1:0] mem_addr,
  output logic [SPL_DW-1:0] mem_wdata,
  // Pointer and state
  output logic [SPL_AW-1:0] working_reg_fifteen,
  output logic busy,
  // Trap requests
  output logic stack_err,
  output logic stack_err_over,
  output logic stack_err_under
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  spl_state_t state_q, state_d;
  logic [SPL_AW-1:0] sp_q, sp_d;
  logic [SPL_AW-1:0] limit_q, limit_d;
  logic [SPL_DW-1:0] hi_word_q, hi_word_d;
  logic mem_req_q, mem_req_d;
  logic mem_we_q, mem_we_d;
  logic [SPL_AW-1:0] mem_addr_q, mem_addr_d;
  logic [SPL_DW-1:0] mem_wdata_q, mem_wdata_d;
  logic err_over_q, err_over_d;
  logic err_under_q, err_under_d;
  logic busy_q, busy_d;
  logic err_any_q, err_any_d;
  logic check_en;
  logic [SPL_AW-1:0] check_addr;
  logic chk_over;
  logic chk_under;
  logic [SPL_DW-1:0] pc_hi_word;
  logic [7:0] pc_top_byte;

  // ----------------------------------------------------------------
  // Address under check
  // ----------------------------------------------------------------
  // Push checks the pointer itself, pop the decremented pointer
  always_comb begin
    check_en = 1'b0;
    check_addr = ea_addr;
    if (state_q == SPL_ST_PC_HI) begin
      check_en = 1'b1;
      check_addr = sp_q;
    end else if (push_req) begin
      check_en = 1'b1;
      check_addr = sp_q;
    end else if (pop_req) begin
      check_en = 1'b1;
      check_addr = sp_q - SPL_WORD_STEP;
    end else if (ea_valid) begin
      check_en = 1'b1;
      check_addr = ea_addr;
    end
  end

  // Limit and lower bound comparison
  spl_bound_cmp u_cmp (
    .addr(check_addr),
    .limit(limit_q),
    .over(chk_over),
    .under(chk_under)
  );

  // ----------------------------------------------------------------
  // Upper word of a pushed program counter
  // ----------------------------------------------------------------
  // Calls clear the top byte, exceptions carry the status byte
  always_comb begin
    pc_top_byte = SPL_ZERO_BYTE;
    if (push_kind == SPL_KIND_EXC) begin
      pc_top_byte = status_low_byte;
    end
    pc_hi_word = {pc_top_byte, 1'b0, push_pc[SPL_PCW-1:SPL_PC_HI_LSB]};
  end

  // ----------------------------------------------------------------
  // Stack sequencer, next values
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    sp_d = sp_q;
    hi_word_d = hi_word_q;
    mem_req_d = 1'b0;
    mem_we_d = 1'b0;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    err_over_d = check_en & chk_over;
    err_under_d = check_en & chk_under;
    err_any_d = check_en & (chk_over | chk_under);
    unique case (state_q)
      SPL_ST_IDLE: begin
        if (push_req) begin
          // Write at the pointer, then step it up
          mem_req_d = 1'b1;
          mem_we_d = 1'b1;
          mem_addr_d = sp_q;
          sp_d = sp_q + SPL_WORD_STEP;
          unique case (push_kind)
            SPL_KIND_CALL, SPL_KIND_EXC: begin
              mem_wdata_d = push_pc[SPL_DW-1:0];
              hi_word_d = pc_hi_word;
              state_d = SPL_ST_PC_HI;
            end
            default: begin
              mem_wdata_d = push_data;
            end
          endcase
        end else if (pop_req) begin
          // Step the pointer down, then read there
          sp_d = sp_q - SPL_WORD_STEP;
          mem_req_d = 1'b1;
          mem_addr_d = sp_q - SPL_WORD_STEP;
        end else if (sp_we) begin
          sp_d = sp_wdata & SPL_ALIGN_MASK;
        end
      end
      SPL_ST_PC_HI: begin
        // Second word of a program counter push
        mem_req_d = 1'b1;
        mem_we_d = 1'b1;
        mem_addr_d = sp_q;
        mem_wdata_d = hi_word_q;
        sp_d = sp_q + SPL_WORD_STEP;
        state_d = SPL_ST_IDLE;
      end
      default: begin
        state_d = SPL_ST_IDLE;
      end
    endcase
    // Busy marks the second word of a program counter push
    busy_d = (state_d == SPL_ST_PC_HI);
  end

  // ----------------------------------------------------------------
  // Stack sequencer, registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SPL_ST_IDLE;
      sp_q <= SPL_SP_RESET;
      hi_word_q <= '0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      err_over_q <= 1'b0;
      err_under_q <= 1'b0;
      busy_q <= 1'b0;
      err_any_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sp_q <= sp_d;
      hi_word_q <= hi_word_d;
      mem_req_q <= mem_req_d;
      mem_we_q <= mem_we_d;
      mem_addr_q <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      err_over_q <= err_over_d;
      err_under_q <= err_under_d;
      busy_q <= busy_d;
      err_any_q <= err_any_d;
    end
  end

  // ----------------------------------------------------------------
  // Stack limit register
  // ----------------------------------------------------------------
  // Written value takes effect from the next cycle on
  always_comb begin
    limit_d = limit_q;
    if (limit_we) begin
      limit_d = limit_wdata & SPL_ALIGN_MASK;
    end
  end

  // No reset: contents stay unknown until software writes them
  always_ff @(posedge clk) begin
    limit_q <= limit_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign working_reg_fifteen = sp_q;
  assign busy = busy_q;
  assign stack_err = err_any_q;
  assign stack_err_over = err_over_q;
  assign stack_err_under = err_under_q;

endmodule // spl_stack_unit

/* File: spl_stack_unit_asserts.sv */
module spl_chk
  import spl_pkg::*;
(
  // Clock, reset, requests
  input wire logic clk,
  input wire logic rstn,
  input wire logic limit_we,
  input wire logic [SPL_AW-1:0] limit_wdata,
  input wire logic push_req,
  input wire logic [1:0] push_kind,
  input wire logic [SPL_PCW-1:0] push_pc,
  input wire logic [7:0] status_low_byte,
  input wire logic pop_req,
  input wire logic ea_valid,
  // Design outputs
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [SPL_AW-1:0] mem_addr,
  input wire logic [SPL_DW-1:0] mem_wdata,
  input wire logic [SPL_AW-1:0] working_reg_fifteen,
  input wire logic busy,
  input wire logic stack_err,
  input wire logic stack_err_over,
  input wire logic stack_err_under
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Checks
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [SPL_AW-1:0] sp;
  logic pu, po, ask;
  logic [SPL_AW-1:0] lim_q;
  logic lim_ok_q;
  // Expected limit, known only once software has written it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lim_ok_q <= 1'b0;
    end else if (limit_we) begin
      lim_ok_q <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (limit_we) begin
      lim_q <= limit_wdata & 16'hFFFE;
    end
  end
  // Taken requests
  assign sp = working_reg_fifteen;
  assign pu = push_req && !busy;
  assign po = pop_req && !push_req && !busy;
  assign ask = push_req || pop_req || ea_valid || busy;
  AST_PUSH: assert property (pu |=> mem_req && mem_we && mem_addr == $past(sp) && sp == $past(sp) + 16'h0002)
    else $error("push wrong");
  AST_POP: assert property (po |=> mem_req && !mem_we && mem_addr == $past(sp) - 16'h0002 && sp == mem_addr)
    else $error("pop wrong");
  AST_CALL: assert property (pu && push_kind == SPL_KIND_CALL |=> busy ##1 !busy && mem_req &&
    mem_addr == $past(sp, 2) + 16'h0002 && mem_wdata == {8'h00, 1'b0, $past(push_pc[22:16], 2)})
    else $error("call word wrong");
  AST_EXC: assert property (pu && push_kind == SPL_KIND_EXC |=> busy ##1 !busy && mem_req &&
    mem_wdata == {$past(status_low_byte, 2), 1'b0, $past(push_pc[22:16], 2)})
    else $error("exception word wrong");
  AST_UNDER: assert property (po && sp < 16'h0802 && sp >= 16'h0002 |=> stack_err_under && stack_err)
    else $error("no underflow");
  AST_CAUSE: assert property (stack_err |-> $past(ask))
    else $error("error without check");
  AST_PULSE: assert property (stack_err && !ask |=> !stack_err)
    else $error("error longer than one cycle");
  AST_OVER: assert property (pu && lim_ok_q && sp > lim_q |=> stack_err_over && stack_err)
    else $error("no overflow");
  AST_AT_LIMIT: assert property (pu && lim_ok_q && sp == lim_q |=> !stack_err_over)
    else $error("overflow at limit");
  AST_ALIGN: assert property (!sp[0] && !(mem_req && mem_addr[0]))
    else $error("odd address");
  cover property (stack_err_over);
  cover property (stack_err_under);
  cover property (busy);
endmodule // spl_chk

bind spl_stack_unit spl_chk u_chk (
  .clk(clk), .rstn(rstn), .limit_we(limit_we), .limit_wdata(limit_wdata),
  .push_req(push_req), .push_kind(push_kind), .push_pc(push_pc), .status_low_byte(status_low_byte),
  .pop_req(pop_req), .ea_valid(ea_valid), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .working_reg_fifteen(working_reg_fifteen), .busy(busy), .stack_err(stack_err),
  .stack_err_over(stack_err_over), .stack_err_under(stack_err_under)
);

/* File: spl_core_model.sv */
module spl_core_model
  import spl_pkg::*;
(
  // Data space and trap side
  input wire logic clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [SPL_AW-1:0] mem_addr,
  input wire logic [SPL_DW-1:0] mem_wdata,
  input wire logic stack_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [SPL_DW-1:0] mem [logic [SPL_AW-1:0]];
  int traps = 0;
  // Store written words, count trap requests
  always @(posedge clk) begin
    if (mem_req && mem_we) mem[mem_addr] = mem_wdata;
    if (stack_err) traps++;
  end
endmodule // spl_core_model

/* File: stack_pointer_limit_check_bench.sv */
module stack_pointer_limit_check_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // -------
  // Signals
  // -------
  logic clk, rstn, sp_we, limit_we, push_req, pop_req, ea_valid;
  logic [1:0] push_kind;
  logic [15:0] sp_wdata, limit_wdata, push_data, ea_addr, mem_addr, mem_wdata, working_reg_fifteen;
  logic [22:0] push_pc;
  logic [7:0] status_low_byte;
  logic mem_req, mem_we, busy, stack_err, stack_err_over, stack_err_under;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  spl_stack_unit dut (
    .clk(clk), .rstn(rstn), .sp_we(sp_we), .sp_wdata(sp_wdata), .limit_we(limit_we),
    .limit_wdata(limit_wdata), .push_req(push_req), .push_kind(push_kind), .push_data(push_data),
    .push_pc(push_pc), .status_low_byte(status_low_byte), .pop_req(pop_req), .ea_valid(ea_valid),
    .ea_addr(ea_addr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .working_reg_fifteen(working_reg_fifteen), .busy(busy), .stack_err(stack_err),
    .stack_err_over(stack_err_over), .stack_err_under(stack_err_under)
  );
  spl_core_model model (
    .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .stack_err(stack_err)
  );
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request for one cycle, then settle
  task automatic op(input logic [4:0] r, input logic [15:0] v, input logic [1:0] k = 2'h0,
                    input logic [22:0] pc = 23'h0);
    {push_req, pop_req, sp_we, ea_valid, limit_we} = r;
    push_kind = k;
    push_pc = pc;
    {push_data, sp_wdata, limit_wdata, ea_addr} = {4{v}};
    @(negedge clk);
    {push_req, pop_req, sp_we, ea_valid, limit_we} = 5'h00;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_limit();
    op(5'h01, 16'h0805);
    for (int i = 0; i < 3; i++) op(5'h10, 16'h5A00 + 16'(i));
    chk(16'(model.traps), 16'h0000);
    op(5'h10, 16'h5A03);
    chk(16'(model.traps), 16'h0001);
    chk(model.mem[16'h0804], 16'h5A02);
    op(5'h08, 16'h0000);
    chk(working_reg_fifteen, 16'h0806);
    chk(16'(model.traps), 16'h0002);
  endtask
  task automatic t_pc();
    op(5'h01, 16'h0FFE);
    op(5'h04, 16'h0901);
    chk(working_reg_fifteen, 16'h0900);
    op(5'h10, 16'h0000, 2'h1, 23'h7F1234);
    op(5'h10, 16'h0000, 2'h2, 23'h05ABCD);
    chk(model.mem[16'h0900], 16'h1234);
    chk(model.mem[16'h0902], 16'h007F);
    chk(model.mem[16'h0904], 16'hABCD);
    chk(model.mem[16'h0906], 16'hA505);
    op(5'h10, 16'h00C3, 2'h3);
    chk(model.mem[16'h0908], 16'h00C3);
    chk(working_reg_fifteen, 16'h090A);
  endtask
  task automatic t_under();
    op(5'h04, 16'h0802);
    op(5'h08, 16'h0000);
    chk(16'(model.traps), 16'h0002);
    op(5'h08, 16'h0000);
    chk(16'(model.traps), 16'h0003);
    chk(working_reg_fifteen, 16'h07FE);
  endtask
  task automatic t_ea();
    op(5'h02, 16'h1000);
    op(5'h02, 16'h0FFE);
    chk(16'(model.traps), 16'h0004);
    op(5'h02, 16'h07FE);
    chk(16'(model.traps), 16'h0005);
  endtask
  // Main sequence
  initial begin
    {rstn, sp_we, limit_we, push_req, pop_req, ea_valid} = 6'h00;
    {push_data, sp_wdata, limit_wdata, ea_addr} = 64'h0;
    push_kind = 2'h0;
    push_pc = 23'h0;
    status_low_byte = 8'hA5;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    t_limit();
    t_pc();
    t_under();
    t_ea();
    print_verdict();
  end
endmodule // stack_pointer_limit_check_bench
